/* File: bench/charger_limit_registers_test.sv */
// self-checking bench for the charger limit register slice
`timescale 1ns/1ps
module charger_limit_registers_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  clr_pkg::clr_req_s req;
  logic ack, inv, reg_mode, opt_act, ofs_dis, vin_pin;
  logic [15:0] rdata, iin_ma, floor_mv, rov_mv;
  logic [6:0] host_lim, opt_lim, iin_code;
  logic [7:0] vbus_code, floor_code;
  logic [11:0] rov_code;
  int bad_count = 0;
  int n_compared = 0;
  initial forever #2 clk = ~clk;
  clr_host_model u_host (.clk(clk), .req(req), .ack_q(ack), .invalid_q(inv), .rdata_q(rdata));
  clr_regs u_dut (.clk(clk), .rst_n(rst_n), .req(req), .ack_q(ack), .invalid_q(inv),
    .rdata_q(rdata), .host_input_current_limit(host_lim), .optimizer_limit(opt_lim),
    .input_current_optimizer_active(opt_act), .offset_disable_bit(ofs_dis),
    .vbus_noload_code(vbus_code), .vin_below_floor_pin(vin_pin),
    .iin_in_force_q(iin_code), .iin_in_force_ma_q(iin_ma), .input_voltage_floor_q(floor_code),
    .floor_mv_q(floor_mv), .reverse_output_voltage_q(rov_code), .rev_out_mv_q(rov_mv),
    .input_regulation_mode_q(reg_mode));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic e);
    logic [15:0] q;
    logic i;
    u_host.word(1'b1, c, d, q, i);
    chk({15'h0000, i}, {15'h0000, e});
    chk({15'h0000, ack}, 16'h0001);
  endtask : wr
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    logic [15:0] q;
    logic i;
    u_host.word(1'b0, c, 16'h0000, q, i);
    chk(q, e);
  endtask : rd
  task automatic t_reset;
    rd(8'h3B, 16'h0000);
    rd(8'h3D, 16'h0B00);
    chk(floor_mv, 16'h1780);
    $display("reset test done");
  endtask : t_reset
  task automatic t_floor;
    wr(8'h3D, 16'hFFFF, 1'b1);
    rd(8'h3D, 16'h0B00);
    wr(8'h3D, 16'h3FFF, 1'b0);
    rd(8'h3D, 16'h3FC0);
    chk({8'h00, floor_code}, 16'h00FF);
    idle(2);
    chk(floor_mv, 16'h4C40);
    wr(8'h3D, 16'h0000, 1'b0);
    idle(2);
    chk(floor_mv, 16'h0C80);
    $display("floor test done");
  endtask : t_floor
  task automatic t_rov;
    wr(8'h3B, 16'h0190, 1'b1);
    wr(8'h3B, 16'hC000, 1'b1);
    wr(8'h3B, 16'h1003, 1'b0);
    rd(8'h3B, 16'h1000);
    chk({4'h0, rov_code}, 16'h0400);
    idle(2);
    chk(rov_mv, 16'h2088);
    wr(8'h3B, 16'h3FFC, 1'b1);
    rd(8'h3B, 16'h1000);
    ofs_dis = 1'b0;
    idle(3);
    chk(rov_mv, 16'h2588);
    $display("reverse voltage test done");
  endtask : t_rov
  task automatic t_iin;
    idle(3);
    chk(iin_ma, 16'h0032);
    rd(8'h22, 16'h0000);
    host_lim = 7'h41;
    idle(3);
    rd(8'h22, 16'h4100);
    chk({9'h000, iin_code}, 16'h0041);
    chk(iin_ma, 16'h0CB2);
    opt_act = 1'b1;
    opt_lim = 7'h7F;
    idle(3);
    rd(8'h22, 16'h7F00);
    chk(iin_ma, 16'h18CE);
    wr(8'h22, 16'h0000, 1'b1);
    wr(8'h10, 16'h1234, 1'b1);
    rd(8'h10, 16'h0000);
    $display("current limit test done");
  endtask : t_iin
  task automatic t_reg;
    vin_pin = 1'b1;
    idle(6);
    chk({15'h0000, reg_mode}, 16'h0001);
    vin_pin = 1'b0;
    idle(6);
    chk({15'h0000, reg_mode}, 16'h0000);
    $display("regulation test done");
  endtask : t_reg
  task automatic t_rerst;
    vbus_code = 8'h10;
    rst_n = 1'b0;
    idle(2);
    rst_n = 1'b1;
    idle(2);
    rd(8'h3B, 16'h0000);
    rd(8'h3D, 16'h0000);
    chk(floor_mv, 16'h0C80);
    chk(rov_mv, 16'h0500);
    $display("second reset test done");
  endtask : t_rerst
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    {host_lim, opt_lim, opt_act, vin_pin} = '0;
    ofs_dis = 1'b1;
    vbus_code = 8'h40;
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    idle(2);
    t_reset;
    t_floor;
    t_rov;
    t_iin;
    t_reg;
    t_rerst;
    report_and_stop;
  end
  // whole run is near 0.4 microsecond; a hundred of them means a hang
  initial begin
    #40000;
    bad_count++;
    report_and_stop;
  end
endmodule : charger_limit_registers_test

/* File: bench/clr_host_model.sv */
// host model issuing word commands to the register slice
`timescale 1ns/1ps
module clr_host_model (
  // clock
  input wire logic clk,
  // register port
  output clr_pkg::clr_req_s req,
  input wire logic ack_q,
  input wire logic invalid_q,
  input wire logic [15:0] rdata_q
);
  initial req = '0;
  // one whole word per command, held over its taking edge
  task automatic word(input logic w, input logic [7:0] c, input logic [15:0] d,
    output logic [15:0] q, output logic inv);
    // one idle edge first, so back-to-back calls never re-raise a strobe in one step
    @(posedge clk);
    #1;
    req.wr = w;
    req.rd = !w;
    req.cmd = c;
    req.wdata = d;
    @(posedge clk);
    #1;
    req.wr = 1'b0;
    req.rd = 1'b0;
    // released data inverted so a stale word is never mistaken for a live one
    req.wdata = ~d;
    q = ack_q ? rdata_q : 16'hDEAD;
    inv = invalid_q;
  endtask : word
endmodule : clr_host_model

/* File: core/clr_pkg.sv */
// package for the charger limit register slice: map, fields, resets, scales
package clr_pkg;
  // command codes of the word registers
  localparam logic [7:0] CLR_CMD_IIN_FORCE = 8'h22;
  localparam logic [7:0] CLR_CMD_REV_OUT_V = 8'h3B;
  localparam logic [7:0] CLR_CMD_VIN_FLOOR = 8'h3D;
  // field positions
  localparam int CLR_IIN_LSB = 8;
  localparam int CLR_IIN_W = 7;
  localparam int CLR_VIN_LSB = 6;
  localparam int CLR_VIN_W = 8;
  localparam int CLR_ROV_LSB = 2;
  localparam int CLR_ROV_W = 12;
  // reserved upper bit masks: a one there makes the write invalid
  localparam logic [15:0] CLR_IIN_RSV_HI = 16'h8000;
  localparam logic [15:0] CLR_VIN_RSV_HI = 16'hC000;
  localparam logic [15:0] CLR_ROV_RSV_HI = 16'hC000;
  // reset values
  localparam logic [11:0] CLR_ROV_RESET = 12'h000;
  localparam logic [7:0] CLR_VIN_RESET = 8'h00;
  // scales in mV / mA
  localparam logic [15:0] CLR_IIN_LSB_MA = 16'h0032;
  localparam logic [15:0] CLR_VIN_LSB_MV = 16'h0040;
  localparam logic [15:0] CLR_VIN_OFS_MV = 16'h0C80;
  localparam logic [7:0] CLR_VIN_DEF_BELOW = 8'h14;
  localparam logic [15:0] CLR_ROV_MSB_MV = 16'h4110;
  localparam logic [15:0] CLR_ROV_OFS_MV = 16'h0500;
  localparam logic [15:0] CLR_ROV_MIN_MV = 16'h0BB8;
  localparam logic [15:0] CLR_ROV_MAX_MV = 16'h5140;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] cmd;
    logic [15:0] wdata;
  } clr_req_s;

  typedef enum logic [0:0] {
    CLR_ST_INIT = 1'b0,
    CLR_ST_RUN = 1'b1
  } clr_state_e;
endpackage : clr_pkg

/* File: core/clr_regs.sv */
// word register slice: in-force current limit, input voltage floor, reverse output voltage
//
// Overview of operation
// RULE_01: in-force limit readable, 7 bits at 14:8
// RULE_02: readback follows host or optimizer limit in use
// RULE_03: code zero reads back as 50 mA
// RULE_04: reserved upper bits read zero; one rejects
// RULE_05: reserved low bits ignored on write
// RULE_06: host writes floor as one word
// RULE_07: floor is 8-bit field at 13:6, 64 mV
// RULE_08: floor adds fixed 3.2 V offset
// RULE_09: input below floor enters regulation mode
// RULE_10: after reset floor is bus minus 1.28 V
// RULE_11: reverse output voltage limited 3 V to 20.8 V
// RULE_12: out-of-range reverse voltage write discarded
// RULE_13: offset disable bit set means no offset
// RULE_14: offset disable clear adds 1.28 V
// RULE_15: reverse voltage 12-bit field at 13:2
// RULE_16: reverse voltage register resets to zero
// RULE_17: word read returns stored value, reserved zero
`timescale 1ns/1ps
module clr_regs (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // word command port from the serial engine
  input wire clr_pkg::clr_req_s req,
  output logic ack_q,
  output logic invalid_q,
  output logic [15:0] rdata_q,
  // analog and neighbouring register side
  input wire logic [6:0] host_input_current_limit,
  input wire logic [6:0] optimizer_limit,
  input wire logic input_current_optimizer_active,
  input wire logic offset_disable_bit,
  input wire logic [7:0] vbus_noload_code,
  input wire logic vin_below_floor_pin,
  // settings toward the regulation loops
  output logic [6:0] iin_in_force_q,
  output logic [15:0] iin_in_force_ma_q,
  output logic [7:0] input_voltage_floor_q,
  output logic [15:0] floor_mv_q,
  output logic [11:0] reverse_output_voltage_q,
  output logic [15:0] rev_out_mv_q,
  output logic input_regulation_mode_q
);

  // target mV of a reverse output code; the top bit weighs 16656 mV
  function automatic logic [15:0] rov_mv(input logic [11:0] code, input logic no_ofs);
    logic [27:0] prod;
    logic [15:0] base;
    prod = 28'(code) * 28'(clr_pkg::CLR_ROV_MSB_MV);
    base = prod[26:11];
    rov_mv = no_ofs ? base : 16'(base + clr_pkg::CLR_ROV_OFS_MV);
  endfunction : rov_mv

  function automatic logic [15:0] vin_mv(input logic [7:0] code);
    logic [23:0] prod;
    prod = 24'(code) * 24'(clr_pkg::CLR_VIN_LSB_MV);
    vin_mv = 16'(prod[15:0] + clr_pkg::CLR_VIN_OFS_MV);
  endfunction : vin_mv

  // state
  clr_pkg::clr_state_e st_q, st_d;
  logic [7:0] vin_q, vin_d;
  logic [11:0] rov_q, rov_d;
  logic ack_d, invalid_d;
  logic [15:0] rdata_d;
  logic [6:0] iin_d;
  logic [15:0] iin_ma_d, floor_mv_d, rov_mv_d;
  logic [2:0] sync_q, sync_d;
  logic reg_d;
  logic [15:0] cand_mv;
  logic [11:0] wr_rov;
  logic [7:0] wr_vin;

  always_comb begin
    st_d = st_q;
    vin_d = vin_q;
    rov_d = rov_q;
    ack_d = req.wr | req.rd;
    invalid_d = 1'b0;
    rdata_d = rdata_q;
    wr_rov = req.wdata[clr_pkg::CLR_ROV_LSB +: clr_pkg::CLR_ROV_W]; // [RULE_05] [RULE_15]
    wr_vin = req.wdata[clr_pkg::CLR_VIN_LSB +: clr_pkg::CLR_VIN_W]; // [RULE_05] [RULE_07]
    cand_mv = rov_mv(wr_rov, offset_disable_bit);
    if (st_q == clr_pkg::CLR_ST_INIT) begin
      // strap-like capture one edge after release, clamped at the code floor
      vin_d = (vbus_noload_code > clr_pkg::CLR_VIN_DEF_BELOW) ?
              8'(vbus_noload_code - clr_pkg::CLR_VIN_DEF_BELOW) : 8'h00; // [RULE_10]
      st_d = clr_pkg::CLR_ST_RUN;
    end
    if (req.wr) begin
      case (req.cmd)
        clr_pkg::CLR_CMD_VIN_FLOOR: begin
          if ((req.wdata & clr_pkg::CLR_VIN_RSV_HI) != 16'h0000) begin
            invalid_d = 1'b1; // [RULE_04]
          end else begin
            vin_d = wr_vin; // [RULE_06] [RULE_07]
          end
        end
        clr_pkg::CLR_CMD_REV_OUT_V: begin
          if ((req.wdata & clr_pkg::CLR_ROV_RSV_HI) != 16'h0000) begin
            invalid_d = 1'b1; // [RULE_04]
          end else if (cand_mv < clr_pkg::CLR_ROV_MIN_MV ||
                       cand_mv > clr_pkg::CLR_ROV_MAX_MV) begin
            invalid_d = 1'b1; // [RULE_11] [RULE_12]
          end else begin
            rov_d = wr_rov;
          end
        end
        // read-only and unmapped words drop the write
        default: invalid_d = 1'b1;
      endcase
    end
    if (req.rd) begin
      case (req.cmd)
        clr_pkg::CLR_CMD_IIN_FORCE: rdata_d = {1'b0, iin_in_force_q, 8'h00}; // [RULE_01] [RULE_04]
        clr_pkg::CLR_CMD_VIN_FLOOR: rdata_d = {2'b00, vin_q, 6'h00}; // [RULE_17]
        clr_pkg::CLR_CMD_REV_OUT_V: rdata_d = {2'b00, rov_q, 2'b00}; // [RULE_17]
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_comb begin
    iin_d = input_current_optimizer_active ? optimizer_limit : host_input_current_limit; // [RULE_02]
    iin_ma_d = (iin_in_force_q == 7'h00) ? clr_pkg::CLR_IIN_LSB_MA :
               16'(22'(iin_in_force_q) * 22'(clr_pkg::CLR_IIN_LSB_MA)); // [RULE_03]
    floor_mv_d = vin_mv(vin_q); // [RULE_08]
    rov_mv_d = rov_mv(rov_q, offset_disable_bit); // [RULE_13] [RULE_14]
    // three stages; only stages two and three decide a change
    sync_d = {sync_q[1:0], vin_below_floor_pin};
    reg_d = (sync_q[2] == sync_q[1]) ? sync_q[2] : input_regulation_mode_q; // [RULE_09]
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= clr_pkg::CLR_ST_INIT;
      vin_q <= clr_pkg::CLR_VIN_RESET;
      rov_q <= clr_pkg::CLR_ROV_RESET; // [RULE_16]
      ack_q <= 1'b0;
      invalid_q <= 1'b0;
      rdata_q <= 16'h0000;
      iin_in_force_q <= 7'h00;
      iin_in_force_ma_q <= 16'h0000;
      floor_mv_q <= 16'h0000;
      rev_out_mv_q <= 16'h0000;
      sync_q <= 3'h0;
      input_regulation_mode_q <= 1'b0;
    end else begin
      st_q <= st_d;
      vin_q <= vin_d;
      rov_q <= rov_d;
      ack_q <= ack_d;
      invalid_q <= invalid_d;
      rdata_q <= rdata_d;
      iin_in_force_q <= iin_d;
      iin_in_force_ma_q <= iin_ma_d;
      floor_mv_q <= floor_mv_d;
      rev_out_mv_q <= rov_mv_d;
      sync_q <= sync_d;
      input_regulation_mode_q <= reg_d;
    end
  end

  assign input_voltage_floor_q = vin_q;
  assign reverse_output_voltage_q = rov_q;

  AST_IIN_READ: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_01]
    req.rd && req.cmd == clr_pkg::CLR_CMD_IIN_FORCE |=>
      rdata_q == {1'b0, $past(iin_in_force_q), 8'h00})
    else $error("in-force limit readback wrong");
  AST_IIN_SRC: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_02]
    input_current_optimizer_active |=> iin_in_force_q == $past(optimizer_limit))
    else $error("optimizer limit not in force");
  AST_IIN_ZERO: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_03]
    iin_in_force_q == 7'h00 |=> iin_in_force_ma_q == 16'h0032)
    else $error("code zero not reported as 50 mA");
  AST_RSV_HI: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_04]
    req.wr && req.cmd == clr_pkg::CLR_CMD_VIN_FLOOR && req.wdata[15:14] != 2'b00
      |=> invalid_q && $stable(vin_q))
    else $error("reserved-bit write not rejected");
  AST_VIN_WR: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_07]
    st_q == clr_pkg::CLR_ST_RUN && req.wr && req.cmd == clr_pkg::CLR_CMD_VIN_FLOOR
      && req.wdata[15:14] == 2'b00 |=> vin_q == $past(req.wdata[13:6]))
    else $error("floor write not stored");
  AST_VIN_MV: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_08]
    vin_q == 8'h00 && $past(vin_q) == 8'h00 |=> floor_mv_q == 16'h0C80)
    else $error("floor offset wrong");
  AST_REG_MODE: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_09]
    vin_below_floor_pin [*4] |=> input_regulation_mode_q)
    else $error("regulation mode not entered");
  AST_ROV_RANGE: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_12]
    rov_q != $past(rov_q) |-> rov_mv($past(req.wdata[13:2]), $past(offset_disable_bit))
      >= 16'h0BB8 && rov_mv($past(req.wdata[13:2]), $past(offset_disable_bit)) <= 16'h5140)
    else $error("out-of-range reverse voltage accepted");
  AST_ROV_OFS: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_14]
    !offset_disable_bit |=> rev_out_mv_q == 16'(int'($past(rov_q)) * 16656 / 2048 + 1280))
    else $error("reverse voltage offset wrong");
  AST_INIT: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_10]
    st_q == clr_pkg::CLR_ST_INIT && !req.wr && vbus_noload_code > 8'h14
      |=> vin_q == 8'($past(vbus_noload_code) - 8'h14))
    else $error("post-reset floor not bus minus 1.28 V");
  AST_HOST_INPUT_CURRENT_LIMIT: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_02]
    !input_current_optimizer_active |=> iin_in_force_q == $past(host_input_current_limit))
    else $error("host limit not in force");
  AST_ROV_KEEP: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_12]
    req.wr && req.cmd == clr_pkg::CLR_CMD_REV_OUT_V && req.wdata[15:14] == 2'b00 &&
      (int'(req.wdata[13:2]) * 16656 / 2048 + (offset_disable_bit ? 0 : 1280) > 20800 ||
       int'(req.wdata[13:2]) * 16656 / 2048 + (offset_disable_bit ? 0 : 1280) < 3000)
      |=> invalid_q && $stable(rov_q))
    else $error("out-of-range reverse voltage not discarded");
  AST_ROV_NOOFS: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_13]
    offset_disable_bit |=> rev_out_mv_q == 16'(int'($past(rov_q)) * 16656 / 2048))
    else $error("reverse voltage carries an offset");
  AST_ACK: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_17]
    req.wr || req.rd |=> ack_q)
    else $error("word command not acknowledged");
  AST_RD_ROV: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_17]
    req.rd && req.cmd == clr_pkg::CLR_CMD_REV_OUT_V |=> rdata_q == {2'b00, $past(rov_q), 2'b00})
    else $error("reverse voltage readback wrong");

endmodule : clr_regs
